// *** verilog/tpc_pkg.sv ***
// package for the transmit per-channel pcm controller
// assumes one 20 mhz clock and same-clock logic on every port
package tpc_pkg;

	// ----------------------------------------------------------------
	// direct host registers
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CFG = 8'h30; // configuration
	localparam logic [7:0] REG_STAT = 8'h31; // access status
	localparam logic [7:0] REG_ADDR = 8'h32; // indirect address/control
	localparam logic [7:0] REG_DATA = 8'h33; // indirect data buffer
	localparam int CFG_FN_EN_BIT = 0; // per_channel_fn_en
	localparam int CFG_IND_BIT = 1; // indirect_mode_sel
	localparam int STAT_BUSY_BIT = 7; // access busy flag
	localparam int ADDR_RNW_BIT = 7; // read_not_write
	localparam logic [7:0] CFG_MASK = 8'h03; // implemented config bits

	// ----------------------------------------------------------------
	// indirect map
	// ----------------------------------------------------------------
	localparam int NUM_CH = 24; // channels per frame
	localparam logic [6:0] IA_PCM_FIRST = 7'h01; // pcm control ch 1
	localparam logic [6:0] IA_IDLE_FIRST = 7'h19; // idle code ch 1
	localparam logic [6:0] IA_SIG_FIRST = 7'h31; // sig control ch 1
	localparam logic [6:0] IA_LAST = 7'h48; // sig control ch 24

	// pcm control byte fields
	localparam int PC_INVERT = 7; // invert whole byte
	localparam int PC_IDLE = 6; // idle_substitute
	localparam int PC_MW = 5; // milliwatt_substitute
	localparam int PC_MSB = 4; // msb_flip
	localparam int PC_ZS_LO = 1; // zero_suppress_sel_lo
	localparam int PC_ZS_HI = 0; // zero_suppress_sel_hi
	localparam logic [7:0] PC_MASK = 8'hF3; // implemented bits

	// signalling control byte fields
	localparam int SC_SRC = 7; // sig_source_sel
	localparam int SC_INS = 6; // sig_insert_en
	localparam logic [7:0] SC_MASK = 8'hCF; // implemented bits

	// zero suppression codes {hi,lo}
	localparam logic [1:0] ZS_NONE = 2'h0;
	localparam logic [1:0] ZS_JAM8 = 2'h1; // jam bit 8, bit 7 where signalling is inserted
	localparam logic [1:0] ZS_DDS = 2'h2; // fixed replacement byte
	localparam logic [1:0] ZS_JAM7 = 2'h3; // jam bit 7
	localparam logic [7:0] DDS_BYTE = 8'h98; // 10011000
	localparam int BIT8_POS = 0; // t1 bit 8 is the lsb
	localparam int BIT7_POS = 1; // t1 bit 7
	localparam int MSB_POS = 7; // t1 bit 1, sent first

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 50; // 20 mhz
	localparam int ACCESS_NS = 640; // longest indirect access
	localparam int ACCESS_CYC = (ACCESS_NS / CLK_NS < 1) ? 1 :
		ACCESS_NS / CLK_NS; // longest time rounds down
	localparam logic [3:0] ACCESS_LAST = 4'(ACCESS_CYC - 1);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TPC_FMT_OTHER = 2'b00, // no robbed-bit signalling
		TPC_FMT_SF = 2'b01, // superframe family
		TPC_FMT_ESF = 2'b10, // extended superframe
		TPC_FMT_RSVD = 2'b11 // treated as other
	} tpc_fmt_t;

	typedef enum logic {
		TPC_ACC_IDLE = 1'b0,
		TPC_ACC_BUSY = 1'b1
	} tpc_acc_t;

	// one timeslot from the backplane
	typedef struct packed {
		logic [7:0] pcm; // channel byte, bit 7 sent first
		logic [4:0] ch; // channel index 0..23
		logic [3:0] sig; // backplane abcd, a in bit 3
		logic sig_frame; // frame carries robbed signalling
		logic [1:0] sig_pos; // 0..3 = a,b,c,d position
		logic second_sf; // second superframe of a pair
	} tpc_slot_t;

	// one timeslot to the basic transmitter
	typedef struct packed {
		logic [7:0] pcm; // processed byte, bit 7 sent first
		logic [4:0] ch; // channel index
	} tpc_out_t;

	localparam int SLOT_W = $bits(tpc_slot_t);
	localparam int FIFO_DEPTH = 32;

endpackage

// *** verilog/tpc_fifo.sv ***
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module tpc_fifo #(
	parameter int WIDTH = 8, // word width
	parameter int DEPTH = 32 // word count, power of two
) (
	input wire logic sys_clk_in, // clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic [WIDTH-1:0] wr_data_in, // word to store
	input wire logic wr_valid_in, // word offered
	output logic wr_ready_out, // room for a word
	output logic [WIDTH-1:0] rd_data_out, // oldest word
	output logic rd_valid_out, // oldest word present
	input wire logic rd_ready_in // consumer takes the word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_ptr_reg; // next write slot
	logic [AW-1:0] rd_ptr_reg; // next read slot
	logic [AW:0] count_reg; // words held
	logic do_wr; // accepted write
	logic do_rd; // accepted read

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
	assign rd_valid_out = (count_reg != '0);
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;
	// show-ahead read keeps the head visible without a bubble
	assign rd_data_out = mem[rd_ptr_reg];

	// storage needs no reset, empty flags guard stale words
	always_ff @(posedge sys_clk_in) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= wr_data_in;
		end
	end

	// pointers and count
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_reg <= count_reg + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// *** verilog/tpc_core.sv ***
// transmit per-channel pcm controller: indirect settings and byte path
// assumes backplane slots and host strobes come from same-clock logic
`timescale 1ns/10ps
module tpc_core (
	input wire logic sys_clk_in, // 20 mhz clock
	input wire logic rstn_in, // sync reset, active low
	// host register port
	input wire logic [7:0] host_addr_in, // register address
	input wire logic host_wr_in, // write strobe, one cycle
	input wire logic host_rd_in, // read strobe, one cycle
	input wire logic [7:0] host_wdata_in, // write data
	output logic [7:0] host_rdata_out, // read data, next cycle
	// framing context
	input wire tpc_pkg::tpc_fmt_t tx_format_in, // transmit format
	// backplane slots in
	input wire tpc_pkg::tpc_slot_t slot_in, // backplane timeslot
	input wire logic slot_valid_in, // timeslot offered
	output logic slot_ready_out, // fifo has room
	// to basic transmitter
	output tpc_pkg::tpc_out_t xmit_out, // processed timeslot
	output logic xmit_valid_out, // timeslot present
	input wire logic xmit_ready_in // transmitter takes it
);
	import tpc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] pcm_ctl_mem [NUM_CH]; // pcm control bytes
	logic [7:0] idle_mem [NUM_CH]; // idle code bytes
	logic [7:0] sig_ctl_mem [NUM_CH]; // signalling control bytes
	logic [2:0] mw_phase_mem [NUM_CH]; // milliwatt phase per channel
	logic [7:0] cfg_reg; // configuration
	logic [7:0] addr_ctl_reg; // indirect address/control
	logic [7:0] data_buf_reg; // indirect data buffer
	logic [7:0] rdata_reg; // host read data
	tpc_acc_t acc_reg; // access state
	tpc_acc_t acc_next;
	logic [3:0] acc_cnt_reg; // access cycle count
	logic acc_done; // last access cycle
	tpc_slot_t head; // fifo head
	logic head_valid; // fifo head present
	logic head_take; // head consumed
	logic out_free; // output stage can load
	tpc_out_t xmit_reg; // output stage
	logic xmit_valid_reg;
	logic [7:0] proc_byte; // processed byte of head
	logic ch_ok; // head channel in range
	logic [4:0] hch; // head channel index

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// which indirect group an address falls in: 0 none,1 pcm,2 idle,3 sig
	function automatic logic [1:0] ia_group(input logic [6:0] a);
		logic [1:0] g;
		g = 2'd0;
		if (a >= IA_SIG_FIRST && a <= IA_LAST) begin
			g = 2'd3;
		end else if (a >= IA_IDLE_FIRST && a < IA_SIG_FIRST) begin
			g = 2'd2;
		end else if (a >= IA_PCM_FIRST) begin
			g = 2'd1;
		end
		return g;
	endfunction

	// channel index inside a group, ascending from each first address
	function automatic logic [4:0] ia_chan(input logic [6:0] a);
		logic [6:0] off;
		off = 7'h00;
		case (ia_group(a))
			2'd1: off = a - IA_PCM_FIRST;
			2'd2: off = a - IA_IDLE_FIRST;
			2'd3: off = a - IA_SIG_FIRST;
			default: off = 7'h00;
		endcase
		return off[4:0];
	endfunction

	// mu-law digital milliwatt, eight bytes
	function automatic logic [7:0] mw_byte(input logic [2:0] p);
		logic [7:0] b;
		case (p)
			3'd0, 3'd3: b = 8'h1E;
			3'd1, 3'd2: b = 8'h0B;
			3'd4, 3'd7: b = 8'h9E;
			default: b = 8'h8B;
		endcase
		return b;
	endfunction

	// ----------------------------------------------------------------
	// host register port
	// ----------------------------------------------------------------
	// config and address/control registers; a new request while busy
	// is dropped so the pending one completes intact
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			cfg_reg <= 8'h00;
			addr_ctl_reg <= 8'h00;
		end else if (host_wr_in) begin
			if (host_addr_in == REG_CFG) begin
				cfg_reg <= host_wdata_in & CFG_MASK;
			end else if (host_addr_in == REG_ADDR &&
				acc_reg == TPC_ACC_IDLE) begin
				addr_ctl_reg <= host_wdata_in;
			end
		end
	end

	// read data is registered, valid the cycle after the strobe
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rdata_reg <= 8'h00;
		end else if (host_rd_in) begin
			case (host_addr_in)
				REG_CFG: rdata_reg <= cfg_reg;
				REG_STAT: rdata_reg <= {acc_reg == TPC_ACC_BUSY,
					7'h00};
				REG_ADDR: rdata_reg <= addr_ctl_reg;
				REG_DATA: rdata_reg <= data_buf_reg;
				default: rdata_reg <= 8'h00; // unmapped reads zero
			endcase
		end
	end
	assign host_rdata_out = rdata_reg;

	// ----------------------------------------------------------------
	// indirect access sequencer
	// ----------------------------------------------------------------
	// a write of the address/control register starts a request
	always_comb begin
		acc_next = acc_reg;
		case (acc_reg)
			TPC_ACC_IDLE: begin
				if (host_wr_in && host_addr_in == REG_ADDR) begin
					acc_next = TPC_ACC_BUSY;
				end
			end
			TPC_ACC_BUSY: begin
				if (acc_done) begin
					acc_next = TPC_ACC_IDLE;
				end
			end
			default: acc_next = TPC_ACC_IDLE;
		endcase
	end
	assign acc_done = (acc_reg == TPC_ACC_BUSY) &&
		(acc_cnt_reg == ACCESS_LAST);

	// state and cycle count of the access
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			acc_reg <= TPC_ACC_IDLE;
			acc_cnt_reg <= 4'h0;
		end else begin
			acc_reg <= acc_next;
			if (acc_reg == TPC_ACC_BUSY) begin
				acc_cnt_reg <= acc_cnt_reg + 4'h1;
			end else begin
				acc_cnt_reg <= 4'h0;
			end
		end
	end

	// data buffer: host loads it for writes, the sequencer fills it on
	// reads; only indirect address 0 reads zero, addresses above IA_LAST decode as pcm
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			data_buf_reg <= 8'h00;
		end else if (acc_done && addr_ctl_reg[ADDR_RNW_BIT]) begin
			case (ia_group(addr_ctl_reg[6:0]))
				2'd1: data_buf_reg <= pcm_ctl_mem[ia_chan(addr_ctl_reg[6:0])];
				2'd2: data_buf_reg <= idle_mem[ia_chan(addr_ctl_reg[6:0])];
				2'd3: data_buf_reg <= sig_ctl_mem[ia_chan(addr_ctl_reg[6:0])];
				default: data_buf_reg <= 8'h00;
			endcase
		end else if (host_wr_in && host_addr_in == REG_DATA) begin
			data_buf_reg <= host_wdata_in;
		end
	end

	// indirect stores, written at the end of a write request
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NUM_CH; i++) begin
				pcm_ctl_mem[i] <= 8'h00;
				idle_mem[i] <= 8'h00;
				sig_ctl_mem[i] <= 8'h00;
			end
		end else if (acc_done && !addr_ctl_reg[ADDR_RNW_BIT]) begin
			case (ia_group(addr_ctl_reg[6:0]))
				2'd1: pcm_ctl_mem[ia_chan(addr_ctl_reg[6:0])] <=
					data_buf_reg & PC_MASK;
				2'd2: idle_mem[ia_chan(addr_ctl_reg[6:0])] <=
					data_buf_reg;
				2'd3: sig_ctl_mem[ia_chan(addr_ctl_reg[6:0])] <=
					data_buf_reg & SC_MASK;
				default: ; // writes to indirect address 0 are dropped
			endcase
		end
	end

	// ----------------------------------------------------------------
	// slot buffer
	// ----------------------------------------------------------------
	// the fifo absorbs transmitter stalls; a full fifo stalls the source
	tpc_fifo #(
		.WIDTH(SLOT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.wr_data_in(slot_in),
		.wr_valid_in(slot_valid_in),
		.wr_ready_out(slot_ready_out),
		.rd_data_out(head),
		.rd_valid_out(head_valid),
		.rd_ready_in(out_free)
	);

	// ----------------------------------------------------------------
	// byte processing
	// ----------------------------------------------------------------
	assign hch = head.ch;
	assign ch_ok = (hch < 5'(NUM_CH));

	// inversion, substitution, signalling, then zero suppression
	always_comb begin
		logic [7:0] pc;
		logic [7:0] sc;
		logic [7:0] b;
		logic [3:0] nib;
		logic [1:0] pos;
		logic sbit;
		logic ins;
		pc = 8'h00;
		sc = 8'h00;
		b = head.pcm;
		nib = 4'h0;
		pos = head.sig_pos;
		sbit = 1'b0;
		ins = 1'b0;
		if (ch_ok) begin
			pc = pcm_ctl_mem[hch];
			sc = sig_ctl_mem[hch];
		end
		if (cfg_reg[CFG_FN_EN_BIT] && ch_ok) begin
			// inversions, overridden by idle, overridden by milliwatt
			if (pc[PC_INVERT]) begin
				b = ~b;
			end
			if (pc[PC_MSB]) begin
				b[MSB_POS] = ~b[MSB_POS];
			end
			if (pc[PC_MW]) begin
				b = mw_byte(mw_phase_mem[hch]);
			end else if (pc[PC_IDLE]) begin
				b = idle_mem[hch];
			end
			// signalling source and superframe c,d reuse
			nib = sc[SC_SRC] ? sc[3:0] : head.sig;
			if (tx_format_in == TPC_FMT_SF && head.second_sf) begin
				pos = {1'b1, head.sig_pos[0]};
			end
			sbit = nib[2'd3 - pos];
			ins = sc[SC_INS] && head.sig_frame &&
				(tx_format_in == TPC_FMT_SF ||
				tx_format_in == TPC_FMT_ESF);
			if (ins) begin
				b[BIT8_POS] = sbit;
			end
			// only an all-zero outgoing byte is touched
			if (b == 8'h00) begin
				case ({pc[PC_ZS_HI], pc[PC_ZS_LO]})
					ZS_JAM8: begin
						if (ins && !sbit) begin
							b[BIT7_POS] = 1'b1;
						end else begin
							b[BIT8_POS] = 1'b1;
						end
					end
					ZS_DDS: b = DDS_BYTE;
					ZS_JAM7: b[BIT7_POS] = 1'b1;
					default: ; // no suppression
				endcase
			end
		end
		proc_byte = b;
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	assign out_free = !xmit_valid_reg || xmit_ready_in;
	assign head_take = head_valid && out_free;

	// holds one processed slot until the transmitter takes it
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			xmit_reg <= '0;
			xmit_valid_reg <= 1'b0;
		end else if (out_free) begin
			xmit_valid_reg <= head_valid;
			if (head_valid) begin
				xmit_reg.pcm <= proc_byte;
				xmit_reg.ch <= head.ch;
			end
		end
	end
	assign xmit_out = xmit_reg;
	assign xmit_valid_out = xmit_valid_reg;

	// milliwatt phase steps once per frame of each channel
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mw_phase_mem[i] <= 3'd0;
			end
		end else if (head_take && ch_ok) begin
			mw_phase_mem[hch] <= mw_phase_mem[hch] + 3'd1;
		end
	end
endmodule

// *** bench/tpc_core_chk.sv ***
// port checker for the transmit per-channel controller
// assumes one clock; host writes are shadowed here to judge reads
`timescale 1ns/10ps
module tpc_core_chk (
	input wire logic sys_clk_in, // clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic [7:0] host_addr_in, // register address
	input wire logic host_wr_in, // write strobe
	input wire logic host_rd_in, // read strobe
	input wire logic [7:0] host_wdata_in, // write data
	input wire logic [7:0] host_rdata_out, // read data
	input wire tpc_pkg::tpc_fmt_t tx_format_in, // transmit format
	input wire tpc_pkg::tpc_slot_t slot_in, // backplane slot
	input wire logic slot_valid_in, // slot offered
	input wire logic slot_ready_out, // fifo room
	input wire tpc_pkg::tpc_out_t xmit_out, // processed slot
	input wire logic xmit_valid_out, // processed slot present
	input wire logic xmit_ready_in // transmitter takes it
);
	import tpc_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	// --------------------------------------------------------------
	// shadows
	// --------------------------------------------------------------
	logic [7:0] cfg_sh_reg; // last config write
	logic [3:0] busy_cnt_reg; // cycles of access left
	// config shadow
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in)
			cfg_sh_reg <= 8'h00;
		else if (host_wr_in && host_addr_in == REG_CFG)
			cfg_sh_reg <= host_wdata_in;
	end
	// busy shadow: a start while busy must not restart the count
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in)
			busy_cnt_reg <= 4'h0;
		else if (busy_cnt_reg != 4'h0)
			busy_cnt_reg <= busy_cnt_reg - 4'h1;
		else if (host_wr_in && host_addr_in == REG_ADDR)
			busy_cnt_reg <= ACCESS_LAST + 4'h1;
	end
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	chk_rst_clear: assert property (disable iff (1'b0)
		!rstn_in |=> !xmit_valid_out && host_rdata_out == 8'h00 &&
		slot_ready_out) else $error("outputs not cleared by reset");
	chk_busy_flag: assert property (
		host_rd_in && host_addr_in == REG_STAT |=> host_rdata_out ==
		{$past(busy_cnt_reg) != 4'h0, 7'h00}) else $error("busy wrong");
	chk_cfg_back: assert property (
		host_rd_in && host_addr_in == REG_CFG |=>
		host_rdata_out == ($past(cfg_sh_reg) & CFG_MASK))
		else $error("config readback wrong");
	chk_unmapped_zero: assert property (
		host_rd_in && (host_addr_in < REG_CFG || host_addr_in > REG_DATA)
		|=> host_rdata_out == 8'h00) else $error("unmapped read not 0");
	chk_rdata_stands: assert property (
		!host_rd_in |=> $stable(host_rdata_out))
		else $error("read data moved without a read");
	chk_out_hold: assert property (
		xmit_valid_out && !xmit_ready_in |=> xmit_valid_out &&
		$stable(xmit_out)) else $error("stalled slot changed");
	chk_out_latency: assert property (
		slot_valid_in && slot_ready_out && !xmit_valid_out |->
		##[1:2] xmit_valid_out) else $error("slot did not come out");
	chk_room_kept: assert property (
		slot_ready_out && !slot_valid_in |=> slot_ready_out)
		else $error("fifo filled without a write");
endmodule
bind tpc_core tpc_core_chk tpc_core_chk_inst (
	.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
	.host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
	.host_rdata_out(host_rdata_out), .tx_format_in(tx_format_in),
	.slot_in(slot_in), .slot_valid_in(slot_valid_in),
	.slot_ready_out(slot_ready_out), .xmit_out(xmit_out),
	.xmit_valid_out(xmit_valid_out), .xmit_ready_in(xmit_ready_in)
);

// *** bench/tpc_xmit_model.sv ***
// model of the basic transmitter that takes processed slots
// assumes the same clock; keeps every accepted slot in order
`timescale 1ns/10ps
module tpc_xmit_model (
	input wire logic sys_clk_in, // clock
	input wire logic rstn_in, // sync reset, active low
	input wire tpc_pkg::tpc_out_t xmit_in, // slot offered
	input wire logic xmit_valid_in, // slot present
	input wire logic hold_in, // refuse every slot
	input wire logic slow_in, // take one slot in four cycles
	output logic xmit_ready_out // slot taken
);
	import tpc_pkg::*;
	logic [1:0] pace_reg; // pacing count for slow mode
	tpc_out_t got[$]; // accepted slots, oldest first
	// free running pace, so stalls land at varied phases
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in)
			pace_reg <= 2'h0;
		else
			pace_reg <= pace_reg + 2'h1;
	end
	assign xmit_ready_out = !hold_in && (!slow_in || pace_reg == 2'h0);
	// record what crosses the handshake
	always @(posedge sys_clk_in) begin
		if (rstn_in && xmit_valid_in && xmit_ready_out)
			got.push_back(xmit_in);
	end
endmodule

// *** bench/tpc_core_tb.sv ***
// self-checking bench for the transmit per-channel controller
// assumes the checker bind and the transmitter model beside it
`timescale 1ns/10ps
module tpc_core_tb;
	import tpc_pkg::*;
	typedef struct packed {
		logic [7:0] ctl; // pcm control byte
		logic [7:0] idl; // idle code byte
		logic [7:0] sc; // signalling control byte
		logic [1:0] fmt; // transmit format
		logic [3:0] sig; // backplane abcd
		logic [3:0] ctx; // {sig frame, second sf, position}
		logic [7:0] pcm; // backplane byte
		logic [7:0] exp; // expected line byte
	} tpc_row_t;
	localparam tpc_row_t ROWS[15] = '{
		'{8'h00, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'h5A},
		'{8'h80, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'hA5},
		'{8'h10, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'hDA},
		'{8'h90, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'h25},
		'{8'hC0, 8'h3C, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'h3C},
		'{8'h81, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'hFF, 8'h98},
		'{8'h83, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'hFF, 8'h02},
		'{8'h82, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'hFF, 8'h01},
		'{8'h01, 8'h00, 8'h00, 2'h0, 4'h0, 4'h0, 8'h5A, 8'h5A},
		'{8'h00, 8'h00, 8'hC9, 2'h1, 4'h0, 4'h8, 8'hFF, 8'hFF},
		'{8'h00, 8'h00, 8'hC9, 2'h1, 4'h0, 4'hC, 8'hFF, 8'hFE},
		'{8'h00, 8'h00, 8'hC9, 2'h2, 4'h0, 4'h9, 8'hFF, 8'hFE},
		'{8'h00, 8'h00, 8'hC9, 2'h0, 4'h0, 4'h9, 8'hFF, 8'hFF},
		'{8'h00, 8'h00, 8'h40, 2'h2, 4'h7, 4'h8, 8'hFF, 8'hFE},
		'{8'h82, 8'h00, 8'hC9, 2'h2, 4'h0, 4'h9, 8'hFF, 8'h02}
	};
	localparam logic [7:0] MW[8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
		8'h9E, 8'h8B, 8'h8B, 8'h9E};
	logic sys_clk_in, rstn_in, host_wr_in, host_rd_in, hold, slow;
	logic [7:0] host_addr_in, host_wdata_in, host_rdata_out, rd;
	tpc_fmt_t tx_format_in;
	tpc_slot_t slot_in;
	logic slot_valid_in, slot_ready_out, xmit_valid_out, xmit_ready_in;
	tpc_out_t xmit_out, o;
	int err_count, num_checks, cyc, n;
	tpc_core tpc_core_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
		.host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
		.host_rdata_out(host_rdata_out), .tx_format_in(tx_format_in),
		.slot_in(slot_in), .slot_valid_in(slot_valid_in),
		.slot_ready_out(slot_ready_out), .xmit_out(xmit_out),
		.xmit_valid_out(xmit_valid_out), .xmit_ready_in(xmit_ready_in));
	tpc_xmit_model tpc_xmit_model_inst (.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in), .xmit_in(xmit_out),
		.xmit_valid_in(xmit_valid_out), .hold_in(hold), .slow_in(slow),
		.xmit_ready_out(xmit_ready_in));
	// --------------------------------------------------------------
	// tasks; each is entered and left 1 ns after a rising edge
	// --------------------------------------------------------------
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] ex);
		num_checks++;
		if (seen !== ex) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hwr(logic [7:0] a, logic [7:0] d);
		host_addr_in = a;
		host_wdata_in = d;
		host_wr_in = 1'b1;
		@(posedge sys_clk_in); #1;
		host_wr_in = 1'b0;
		// idle edge so the next strobe rises cleanly
		@(posedge sys_clk_in);
		#1;
	endtask
	task automatic hrd(logic [7:0] a, output logic [7:0] d);
		host_addr_in = a;
		host_rd_in = 1'b1;
		@(posedge sys_clk_in); #1;
		host_rd_in = 1'b0;
		d = host_rdata_out;
		@(posedge sys_clk_in);
		#1;
	endtask
	// poll until the access ends; bounded so a stuck flag shows
	task automatic wait_idle();
		logic [7:0] s;
		for (int k = 0; k < 40; k++) begin
			hrd(REG_STAT, s);
			if (!s[STAT_BUSY_BIT])
				return;
		end
		chk("busy clears", s, 8'h00);
	endtask
	task automatic ind_wr(logic [6:0] ia, logic [7:0] d);
		hwr(REG_DATA, d);
		hwr(REG_ADDR, {1'b0, ia});
		wait_idle();
	endtask
	task automatic ind_rd(logic [6:0] ia, output logic [7:0] d);
		hwr(REG_ADDR, {1'b1, ia});
		wait_idle();
		hrd(REG_DATA, d);
	endtask
	task automatic send(logic [7:0] p, logic [4:0] c, logic [3:0] g,
		logic [3:0] x);
		logic ok;
		slot_in = {p, c, g, x[3], x[1:0], x[2]};
		slot_valid_in = 1'b1;
		for (int k = 0; k < 100; k++) begin
			ok = slot_ready_out;
			@(posedge sys_clk_in); #1;
			if (ok)
				break;
		end
		slot_valid_in = 1'b0;
		@(posedge sys_clk_in);
		#1;
	endtask
	task automatic expect_out(string nm, logic [7:0] ex);
		for (int k = 0; k < 200; k++) begin
			if (tpc_xmit_model_inst.got.size() != 0)
				break;
			@(posedge sys_clk_in); #1;
		end
		o = 'x;
		if (tpc_xmit_model_inst.got.size() != 0)
			o = tpc_xmit_model_inst.got.pop_front();
		chk(nm, o.pcm, ex);
	endtask
	// --------------------------------------------------------------
	// clock, hang guard and main sequence
	// --------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// about 1500 cycles are needed; the ceiling leaves ample room
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		{rstn_in, host_wr_in, host_rd_in, hold, slow} = 5'h00;
		{host_addr_in, host_wdata_in, slot_valid_in} = 17'h0_0000;
		slot_in = '0;
		tx_format_in = TPC_FMT_OTHER;
		repeat (3) @(posedge sys_clk_in);
		#1 rstn_in = 1'b1;
		hrd(REG_CFG, rd);
		chk("cfg reset", rd, 8'h00);
		ind_rd(IA_PCM_FIRST, rd);
		chk("store reset", rd, 8'h00);
		chk("ready reset", {7'h00, slot_ready_out}, 8'h01);
		$display("reset test done");
		hwr(REG_CFG, 8'hFF);
		hrd(REG_CFG, rd);
		chk("cfg reserved", rd, CFG_MASK);
		hwr(REG_CFG, 8'h01);
		// ordinary cases: one channel per row
		foreach (ROWS[i]) begin
			ind_wr(IA_PCM_FIRST + 7'(i), ROWS[i].ctl);
			ind_wr(IA_IDLE_FIRST + 7'(i), ROWS[i].idl);
			ind_wr(IA_SIG_FIRST + 7'(i), ROWS[i].sc);
			tx_format_in = tpc_fmt_t'(ROWS[i].fmt);
			slow = (i > 7);
			send(ROWS[i].pcm, 5'(i), ROWS[i].sig, ROWS[i].ctx);
			expect_out("row byte", ROWS[i].exp);
		end
		$display("row test done");
		// map edges, masks and unmapped indirect place
		foreach (MW[i]) begin
			n = (i < 4) ? i : 0;
			ind_wr(7'h18 + 7'(n * 24), 8'hFF);
		end
		ind_rd(7'h18, rd);
		chk("pcm ctl 24", rd, 8'hF3);
		ind_rd(7'h30, rd);
		chk("idle 24", rd, 8'hFF);
		ind_rd(7'h48, rd);
		chk("sig ctl 24", rd, 8'hCF);
		ind_rd(7'h60, rd);
		chk("unmapped", rd, 8'h00);
		ind_rd(7'h1D, rd);
		chk("idle ch 5", rd, 8'h3C);
		hrd(8'h35, rd);
		chk("unmapped reg", rd, 8'h00);
		// start while busy is dropped
		hwr(REG_DATA, 8'h55);
		hwr(REG_ADDR, 8'h20);
		hwr(REG_ADDR, 8'h21);
		wait_idle();
		ind_rd(7'h20, rd);
		chk("first start", rd, 8'h55);
		ind_rd(7'h21, rd);
		chk("start while busy", rd, 8'h00);
		$display("map test done");
		// milliwatt over idle, in a signalling format, cycling
		tx_format_in = TPC_FMT_SF;
		ind_wr(IA_PCM_FIRST + 7'h10, 8'hE0);
		for (int k = 0; k < 9; k++) begin
			send(8'h5A, 5'h10, 4'h0, 4'h0);
			expect_out("milliwatt", MW[k % 8]);
		end
		// enable off passes bytes unchanged
		hwr(REG_CFG, 8'h00);
		send(8'h5A, 5'h01, 4'h0, 4'h0);
		expect_out("bypass", 8'h5A);
		$display("milliwatt and bypass test done");
		// fill with the transmitter refusing, then drain slowly
		hwr(REG_CFG, 8'h01);
		hold = 1'b1;
		for (n = 0; n < 40 && slot_ready_out; n++)
			send(8'(n), 5'h1E, 4'h0, 4'h0);
		chk("fill count", 8'(n >= 32 && n <= 33), 8'h01);
		hold = 1'b0;
		for (int k = 0; k < n; k++) begin
			expect_out("drain", 8'(k));
			chk("drain ch", {3'h0, o.ch}, 8'h1E);
		end
		chk("empty valid", {7'h00, xmit_valid_out}, 8'h00);
		$display("fifo test done");
		// reset in mid-run clears the settings again
		rstn_in = 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1 rstn_in = 1'b1;
		hrd(REG_CFG, rd);
		chk("cfg second reset", rd, 8'h00);
		$display("second reset test done");
		give_verdict();
	end
endmodule
